// File: rtl/wave_pkg.sv
package wave_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_POL   = 8'h04;
  localparam logic [7:0] OFF_SRC   = 8'h08;
  localparam logic [7:0] OFF_CLK   = 8'h0C;
  localparam logic [7:0] OFF_RISE  = 8'h10;
  localparam logic [7:0] OFF_FALL  = 8'h14;
  localparam logic [7:0] OFF_SHDN  = 8'h18;

  // field positions
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_LD_BIT = 6;
  localparam int POL_IN_BIT  = 5;
  localparam int CLK_CS_BIT  = 0;
  localparam int SHDN_BIT    = 7;

  // widths and counts
  localparam int DB_WIDTH  = 6;
  localparam int SRC_W     = 4;
  localparam int NUM_SRC   = 14;
  localparam int NUM_OUT   = 4;
  localparam int NUM_DB    = 2;
  localparam int OSC_MHZ   = 16;

  // reset values
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [3:0] POL_RST  = 4'h0;
  localparam logic [3:0] OVR_RST  = 4'h0;

  // bus constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef enum logic [2:0] {
    MODE_ASYNC_STEER = 3'h0,
    MODE_SYNC_STEER  = 3'h1,
    MODE_FWD_BRIDGE  = 3'h2,
    MODE_REV_BRIDGE  = 3'h3,
    MODE_HALF_BRIDGE = 3'h4,
    MODE_PUSH_PULL   = 3'h5
  } mode_e;

  // field order puts select code 0 in bit 0
  typedef struct packed {
    logic logic_cell_four_out;
    logic logic_cell_three_out;
    logic logic_cell_two_out;
    logic logic_cell_one_out;
    logic numeric_oscillator_out;
    logic pulse_gen_six_out;
    logic pulse_gen_five_out;
    logic capcomp_four_out;
    logic capcomp_three_out;
    logic capcomp_two_out;
    logic capcomp_one_out;
    logic comparator_two_out;
    logic comparator_one_out;
    logic pin_routed_input;
  } pulse_sources_s;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } ahb_req_s;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } ahb_rsp_s;

endpackage

// File: rtl/dead_delay.sv
`timescale 1ns/100ps
module dead_delay #(
  parameter int W = 6
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         level_in,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] count_in,
  output logic              on_out
);
  import wave_pkg::*;

  if (W < 1 || W > 16) begin : g_bad_width
    $error("dead_delay: width out of range");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         on;
  } state_s;

  state_s s;
  state_s next_s;

  always_comb begin
    next_s = s;
    if (!level_in) begin
      // a level drop before the count ends cancels the turn-on
      next_s.cnt = '0;
      next_s.on  = 1'b0;
    end else if (!s.on) begin
      if (s.cnt == count_in) begin
        next_s.on = 1'b1;
      end else if (tick_in) begin
        next_s.cnt = s.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign on_out = s.on;
endmodule // dead_delay

// File: rtl/complementary_waveform_deadband.sv
`timescale 1ns/100ps
// Notes on behaviour
// - full bridge: dead band on modulated output only
// - one bit picks system or fast oscillator
// - oscillator timing keeps running during sleep
// - 4-bit field picks one of fourteen inputs
// - enabling starts with all drives cleared
// - per-output polarity bit, set means active-low
// - polarity never alters shutdown override levels
// - two independent 6-bit counters, rise and fall
// - dead band only in half/full bridge
// - count timing-clock ticks from zero to value
// - half bridge: delay A after input rise
// - reverse delay only forward-to-reverse, on B
// - half bridge: delay B after input fall
// - forward delay only reverse-to-forward, on D
// - interval spans 0 to 63 timing periods
// - interval starts at edge; zero means none
// - input reversal before count end: no output
// - counts double-buffered, loaded per enable state
// - async input gives one period of jitter
// - mode 010 forward, 011 reverse full bridge
// - direction change waits for next input rise
module complementary_waveform_deadband #(
  parameter int DB_W = wave_pkg::DB_WIDTH
) (
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire wave_pkg::ahb_req_s       ahb_in,
  output wave_pkg::ahb_rsp_s            ahb_out,
  input  wire wave_pkg::pulse_sources_s sources_in,
  input  wire logic                     internal_fast_oscillator_in,
  input  wire logic                     sleep_in,
  output logic                          drive_out_a,
  output logic                          drive_out_b,
  output logic                          drive_out_c,
  output logic                          drive_out_d
);
  import wave_pkg::*;

  if (DB_W < 1 || DB_W > 16) begin : g_bad_width
    $error("dead band width out of range");
  end

  if (NUM_SRC > (1 << SRC_W)) begin : g_bad_src
    $error("source count exceeds select field");
  end

  if (NUM_OUT != 4 || NUM_DB != 2) begin : g_bad_shape
    $error("output stage built for four drives and two counters");
  end

  typedef struct packed {
    logic            en;
    logic            ld;
    logic [2:0]      mode;
    logic [3:0]      pol;
    logic [3:0]      src;
    logic            cs;
    logic [DB_W-1:0] rise_hold;
    logic [DB_W-1:0] fall_hold;
    logic [DB_W-1:0] rise_act;
    logic [DB_W-1:0] fall_act;
    logic            shdn;
    logic [3:0]      ovr;
    logic            wr_pend;
    logic [7:0]      wr_addr;
    ahb_rsp_s        rsp;
    logic            in_s1;
    logic            in_s2;
    logic            in_prev;
    logic            osc_s1;
    logic            osc_s2;
    logic            osc_prev;
    logic            seen_fall;
    logic            dir_rev;
    logic            pp_sel;
    logic [3:0]      drv;
  } state_s;

  state_s s;
  state_s next_s;

  logic [NUM_SRC-1:0] src_vec;
  logic               sel_bit;
  logic               in_rise;
  logic               in_fall;
  logic               osc_rise;
  logic               tick;
  logic [NUM_DB-1:0]  db_level;
  logic [NUM_DB-1:0]  db_on;
  logic [DB_W-1:0]    db_count [NUM_DB];
  logic               accept;
  logic [31:0]        rd_val;
  logic [31:0]        wd;
  logic [3:0]         raw;
  logic               fb_mode;
  logic               pp_now;

  assign src_vec  = sources_in;
  // select mux sits ahead of the synchroniser: a select change
  // can cost one stray sample, never a metastable edge
  assign sel_bit  = (s.src < SRC_W'(NUM_SRC)) ? src_vec[s.src] : 1'b0;
  assign in_rise  = s.in_s2 & ~s.in_prev;
  assign in_fall  = ~s.in_s2 & s.in_prev;
  assign osc_rise = s.osc_s2 & ~s.osc_prev;
  // system clock stops in sleep, fast oscillator does not
  assign tick     = s.cs ? osc_rise : ~sleep_in;
  assign fb_mode  = (s.mode == MODE_FWD_BRIDGE) || (s.mode == MODE_REV_BRIDGE);
  // the rise that steps the sequencer already steers its own pulse
  assign pp_now   = s.pp_sel ^ in_rise;
  assign db_count[0] = s.rise_act;
  assign db_count[1] = s.fall_act;
  assign accept   = ahb_in.hsel & (ahb_in.htrans == HTRANS_NONSEQ) & ahb_in.hready;
  assign wd       = ahb_in.hwdata;

  // dead-band level per counter: edge-started in half bridge,
  // direction-started in full bridge, idle elsewhere
  always_comb begin
    db_level = '0;
    if (s.en) begin
      if (s.mode == MODE_HALF_BRIDGE) begin
        db_level[0] = s.in_s2;
        db_level[1] = ~s.in_s2;
      end else if (fb_mode) begin
        db_level[0] = s.dir_rev;
        db_level[1] = ~s.dir_rev;
      end
    end
  end

  // a zero count still costs the one register stage of the delay
  for (genvar g = 0; g < NUM_DB; g++) begin : g_db
    dead_delay #(
      .W (DB_W)
    ) u_delay (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .level_in (db_level[g]),
      .tick_in  (tick),
      .count_in (db_count[g]),
      .on_out   (db_on[g])
    );
  end

  // unpolarised drive per mode, bit 0 is output A
  always_comb begin
    raw = '0;
    case (s.mode)
      MODE_HALF_BRIDGE: begin
        raw[0] = s.in_s2 & db_on[0];
        raw[1] = ~s.in_s2 & db_on[1];
        raw[2] = raw[0];
        raw[3] = raw[1];
      end
      MODE_PUSH_PULL: begin
        raw[0] = s.in_s2 & ~pp_now;
        raw[1] = s.in_s2 & pp_now;
        raw[2] = raw[0];
        raw[3] = raw[1];
      end
      MODE_FWD_BRIDGE, MODE_REV_BRIDGE: begin
        // statics switch at once, no dead band
        raw[0] = ~s.dir_rev;
        raw[2] = s.dir_rev;
        raw[1] = s.dir_rev & s.in_s2 & db_on[0];
        raw[3] = ~s.dir_rev & s.in_s2 & db_on[1];
      end
      MODE_ASYNC_STEER, MODE_SYNC_STEER: begin
        raw = {NUM_OUT{s.in_s2}};
      end
      default: begin
        raw = '0;
      end
    endcase
  end

  // register read mux, reserved bits read zero
  always_comb begin
    rd_val = '0;
    case (ahb_in.haddr[7:0])
      OFF_CTRL: begin
        rd_val[CTRL_EN_BIT] = s.en;
        rd_val[CTRL_LD_BIT] = s.ld;
        rd_val[2:0]         = s.mode;
      end
      OFF_POL: begin
        rd_val[POL_IN_BIT] = s.in_s2;
        rd_val[3:0]        = s.pol;
      end
      OFF_SRC: begin
        rd_val[SRC_W-1:0] = s.src;
      end
      OFF_CLK: begin
        rd_val[CLK_CS_BIT] = s.cs;
      end
      OFF_RISE: begin
        rd_val[DB_W-1:0] = s.rise_hold;
      end
      OFF_FALL: begin
        rd_val[DB_W-1:0] = s.fall_hold;
      end
      OFF_SHDN: begin
        rd_val[SHDN_BIT] = s.shdn;
        rd_val[3:0]      = s.ovr;
      end
      default: begin
        rd_val = '0;
      end
    endcase
    if (ahb_in.haddr[31:8] != '0) begin
      rd_val = '0;
    end
  end

  always_comb begin
    next_s = s;

    // two-flop synchronisers ahead of any edge logic
    next_s.in_s1    = sel_bit;
    next_s.in_s2    = s.in_s1;
    next_s.in_prev  = s.in_s2;
    next_s.osc_s1   = internal_fast_oscillator_in;
    next_s.osc_s2   = s.osc_s1;
    next_s.osc_prev = s.osc_s2;

    // zero-wait slave, always OKAY
    next_s.rsp.hreadyout = 1'b1;
    next_s.rsp.hresp     = HRESP_OKAY;
    next_s.rsp.hrdata    = '0;
    next_s.wr_pend       = 1'b0;
    if (accept) begin
      if (ahb_in.hwrite) begin
        next_s.wr_pend = 1'b1;
        next_s.wr_addr = (ahb_in.haddr[31:8] == '0) ? ahb_in.haddr[7:0] : 8'hFF;
      end else begin
        next_s.rsp.hrdata = rd_val;
      end
    end

    // full-bridge direction follows mode at once while disabled, else only at an input rise
    if (!s.en) begin
      next_s.dir_rev = (s.mode == MODE_REV_BRIDGE);
    end else if (in_rise && fb_mode) begin
      next_s.dir_rev = (s.mode == MODE_REV_BRIDGE);
    end

    // push-pull sequencer, first pulse lands on A
    if (!s.en) begin
      next_s.pp_sel = 1'b1;
    end else if (in_rise) begin
      next_s.pp_sel = ~s.pp_sel;
    end

    // buffered count transfer: first fall, then the next rise
    if (!s.en) begin
      next_s.ld        = 1'b0;
      next_s.seen_fall = 1'b0;
    end else if (s.ld) begin
      if (in_fall) begin
        next_s.seen_fall = 1'b1;
      end
      if (in_rise && s.seen_fall) begin
        next_s.rise_act  = s.rise_hold;
        next_s.fall_act  = s.fall_hold;
        next_s.ld        = 1'b0;
        next_s.seen_fall = 1'b0;
      end
    end

    // data phase of a write; a set of ld beats the hardware clear
    if (s.wr_pend) begin
      case (s.wr_addr)
        OFF_CTRL: begin
          next_s.en   = wd[CTRL_EN_BIT];
          next_s.mode = wd[2:0];
          if (wd[CTRL_LD_BIT] && s.en) begin
            next_s.ld = 1'b1;
          end
        end
        OFF_POL: begin
          next_s.pol = wd[3:0];
        end
        OFF_SRC: begin
          next_s.src = wd[SRC_W-1:0];
        end
        OFF_CLK: begin
          next_s.cs = wd[CLK_CS_BIT];
        end
        OFF_RISE: begin
          next_s.rise_hold = wd[DB_W-1:0];
        end
        OFF_FALL: begin
          next_s.fall_hold = wd[DB_W-1:0];
        end
        OFF_SHDN: begin
          next_s.shdn = wd[SHDN_BIT];
          next_s.ovr  = wd[3:0];
        end
        default: begin
          next_s.en = s.en;
        end
      endcase
    end

    // while disabled the active counts track every write at once
    if (!s.en) begin
      next_s.rise_act = next_s.rise_hold;
      next_s.fall_act = next_s.fall_hold;
    end

    // output stage
    if (!s.en) begin
      next_s.drv = '0;
    end else if (s.shdn) begin
      next_s.drv = s.ovr;
    end else begin
      next_s.drv = raw ^ s.pol;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s               <= '0;
      s.mode          <= MODE_RST;
      s.pol           <= POL_RST;
      s.ovr           <= OVR_RST;
      s.pp_sel        <= 1'b1;
      s.rsp.hreadyout <= 1'b1;
      s.rsp.hresp     <= HRESP_OKAY;
    end else begin
      s <= next_s;
    end
  end

  assign ahb_out     = s.rsp;
  assign drive_out_a = s.drv[0];
  assign drive_out_b = s.drv[1];
  assign drive_out_c = s.drv[2];
  assign drive_out_d = s.drv[3];
endmodule // complementary_waveform_deadband

// File: sim/wave_checker.sv
`timescale 1ns/100ps
module wave_checker (
  input wire logic               clk_in,
  input wire logic               rst_in,
  input wire wave_pkg::ahb_req_s ahb_in,
  input wire wave_pkg::ahb_rsp_s ahb_out,
  input wire logic               drive_out_a,
  input wire logic               drive_out_b,
  input wire logic               drive_out_c,
  input wire logic               drive_out_d
);
  import wave_pkg::*;
  logic       wr;
  logic [7:0] adr, ctl, pol, sd;
  logic [2:0] qt;
  logic [3:0] drv, raw;
  logic       on;
  assign drv = {drive_out_d, drive_out_c, drive_out_b, drive_out_a};
  assign raw = drv ^ pol[3:0];
  // seven quiet cycles let output latency settle after any write
  assign on = qt == 3'h7 && ctl[CTRL_EN_BIT] && !sd[SHDN_BIT];
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr  <= 1'b0;
      ctl <= 8'h00;
      pol <= 8'h00;
      sd  <= 8'h00;
      qt  <= 3'h0;
    end else begin
      wr  <= ahb_in.hsel && ahb_in.htrans == HTRANS_NONSEQ && ahb_in.hready && ahb_in.hwrite;
      adr <= ahb_in.haddr[7:0];
      qt  <= wr ? 3'h0 : qt + {2'h0, qt != 3'h7};
      if (wr && adr == OFF_CTRL) ctl <= ahb_in.hwdata[7:0];
      if (wr && adr == OFF_POL) pol <= ahb_in.hwdata[7:0];
      if (wr && adr == OFF_SHDN) sd <= ahb_in.hwdata[7:0];
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_okay;
    ahb_out.hresp == HRESP_OKAY && ahb_out.hreadyout;
  endproperty
  a_okay: assert property (p_okay) else $error("bus answer not okay");
  property p_rdata;
    !$past(ahb_in.hsel && ahb_in.htrans == HTRANS_NONSEQ && ahb_in.hready && !ahb_in.hwrite)
      |-> ahb_out.hrdata == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside data phase");
  property p_rst;
    $fell(rst_in) |-> drv == 4'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("drives not cleared by reset");
  property p_off;
    qt == 3'h7 && !ctl[CTRL_EN_BIT] |-> drv == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("drive while disabled");
  property p_shdn;
    qt == 3'h7 && ctl[CTRL_EN_BIT] && sd[SHDN_BIT] |-> drv == sd[3:0];
  endproperty
  a_shdn: assert property (p_shdn) else $error("override level altered");
  property p_half;
    on && ctl[2:0] == MODE_HALF_BRIDGE |-> !(raw[0] && raw[1]);
  endproperty
  a_half: assert property (p_half) else $error("half bridge overlap");
  property p_bridge;
    on && ctl[2:1] == 2'b01 |-> (raw[0] ^ raw[2]) && !(raw[1] && raw[3]);
  endproperty
  a_bridge: assert property (p_bridge) else $error("full bridge static outputs wrong");
  property p_steer;
    on && ctl[2:1] == 2'b00 |-> raw == 4'h0 || raw == 4'hF;
  endproperty
  a_steer: assert property (p_steer) else $error("steering outputs differ");
endmodule // wave_checker
bind complementary_waveform_deadband wave_checker i_chk (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .ahb_in(ahb_in),
  .ahb_out(ahb_out),
  .drive_out_a(drive_out_a),
  .drive_out_b(drive_out_b),
  .drive_out_c(drive_out_c),
  .drive_out_d(drive_out_d)
);

// File: sim/gate_driver_model.sv
`timescale 1ns/100ps
module gate_driver_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [1:0] drive_in,
  input  wire logic       arm_in,
  output logic            shoot_out
);
  // one leg: high side on a, low side on b; both on is a short
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shoot_out <= 1'b0;
    end else if (arm_in && drive_in == 2'b11) begin
      shoot_out <= 1'b1;
    end
  end
endmodule // gate_driver_model

// File: sim/complementary_waveform_deadband_test.sv
`timescale 1ns/100ps
module complementary_waveform_deadband_test;
  import wave_pkg::*;
  logic           clk_in = 1'b0;
  logic           rst_in = 1'b1;
  logic           osc    = 1'b0;
  logic           sleep  = 1'b0;
  logic           arm    = 1'b0;
  logic           shoot;
  logic [3:0]     drv;
  logic [31:0]    q;
  int             error_cnt, check_count, cyc, n, d0r, d0f;
  ahb_req_s       req = '0;
  ahb_req_s       bus_req;
  ahb_rsp_s       rsp;
  pulse_sources_s src = '0;
  always #5 clk_in = ~clk_in;
  always #31.25 osc = ~osc;
  always_comb begin
    bus_req        = req;
    bus_req.hready = rsp.hreadyout;
  end
  complementary_waveform_deadband i_dut (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ahb_in(bus_req),
    .ahb_out(rsp),
    .sources_in(src),
    .internal_fast_oscillator_in(osc),
    .sleep_in(sleep),
    .drive_out_a(drv[0]),
    .drive_out_b(drv[1]),
    .drive_out_c(drv[2]),
    .drive_out_d(drv[3])
  );
  gate_driver_model i_gate (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .drive_in(drv[1:0]),
    .arm_in(arm),
    .shoot_out(shoot)
  );
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    req.hsel   <= 1'b1;
    req.haddr  <= {24'h0, a};
    req.htrans <= HTRANS_NONSEQ;
    req.hwrite <= w;
    req.hsize  <= 3'h2;
    do @(posedge clk_in); while (rsp.hreadyout !== 1'b1);
    req.htrans <= 2'h0;
    req.hwdata <= d;
    do @(posedge clk_in); while (rsp.hreadyout !== 1'b1);
    q = rsp.hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(q, e);
  endtask
  // cycles from an input edge until the waiting output turns on
  task automatic edge_delay(input logic v, output int d);
    src.pin_routed_input <= v;
    d = 0;
    do begin
      @(posedge clk_in);
      d++;
    end while (drv[!v] !== 1'b1 && d < 200);
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rdchk(OFF_CTRL, 32'h0);
    wr(8'h1C, 32'h5A);
    rdchk(8'h1C, 32'h0);
    wr(OFF_RISE, 32'h3F);
    rdchk(OFF_RISE, 32'h3F);
    wr(OFF_RISE, 32'h0);
    wr(OFF_CTRL, 32'hC4);
    rdchk(OFF_CTRL, 32'h84);
    arm <= 1'b1;
    edge_delay(1'b1, d0r);
    edge_delay(1'b0, d0f);
    chk(d0r < 10 && d0f < 10, 1'b1);
    wr(OFF_RISE, 32'h6);
    wr(OFF_FALL, 32'h3);
    rdchk(OFF_FALL, 32'h3);
    wr(OFF_CTRL, 32'hC4);
    edge_delay(1'b1, n);
    chk(n, d0r);
    edge_delay(1'b0, n);
    chk(n, d0f);
    edge_delay(1'b1, n);
    rdchk(OFF_CTRL, 32'h84);
    edge_delay(1'b0, n);
    chk(n, d0f + 3);
    edge_delay(1'b1, n);
    chk(n, d0r + 6);
    src.pin_routed_input <= 1'b0;
    repeat (20) @(posedge clk_in);
    src.pin_routed_input <= 1'b1;
    repeat (3) @(posedge clk_in);
    src.pin_routed_input <= 1'b0;
    n = 0;
    repeat (20) begin
      @(posedge clk_in);
      if (drv[0] !== 1'b0) n++;
    end
    chk(n, 0);
    chk(shoot, 1'b0);
    arm <= 1'b0;
    wr(OFF_CTRL, 32'h0);
    wr(OFF_POL, 32'hF);
    rdchk(OFF_POL, 32'hF);
    wr(OFF_CTRL, 32'h80);
    repeat (8) @(posedge clk_in);
    chk(drv, 4'hF);
    wr(OFF_SHDN, 32'h85);
    rdchk(OFF_SHDN, 32'h85);
    repeat (4) @(posedge clk_in);
    chk(drv, 4'h5);
    wr(OFF_SHDN, 32'h0);
    wr(OFF_POL, 32'h0);
    for (int k = 0; k < NUM_SRC; k++) begin
      wr(OFF_SRC, k);
      rdchk(OFF_SRC, k);
      src <= pulse_sources_s'(14'h1 << k);
      repeat (8) @(posedge clk_in);
      chk(drv, 4'hF);
      rdchk(OFF_POL, 32'h20);
      src <= pulse_sources_s'(~(14'h1 << k));
      repeat (8) @(posedge clk_in);
      chk(drv, 4'h0);
    end
    wr(OFF_SRC, 32'hF);
    src <= '1;
    repeat (8) @(posedge clk_in);
    chk(drv, 4'h0);
    wr(OFF_CTRL, 32'h81);
    wr(OFF_SRC, 32'h0);
    repeat (8) @(posedge clk_in);
    chk(drv, 4'hF);
    src <= '0;
    wr(OFF_SRC, 32'h0);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CTRL, 32'h82);
    repeat (8) @(posedge clk_in);
    chk(drv, 4'h1);
    wr(OFF_CTRL, 32'h83);
    repeat (8) @(posedge clk_in);
    chk(drv, 4'h1);
    src.pin_routed_input <= 1'b1;
    repeat (30) @(posedge clk_in);
    chk(drv, 4'h6);
    wr(OFF_CTRL, 32'h82);
    src.pin_routed_input <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk(drv, 4'h4);
    src.pin_routed_input <= 1'b1;
    repeat (30) @(posedge clk_in);
    chk(drv, 4'h9);
    wr(OFF_CTRL, 32'h0);
    src.pin_routed_input <= 1'b0;
    wr(OFF_CTRL, 32'h85);
    arm <= 1'b1;
    repeat (8) @(posedge clk_in);
    src.pin_routed_input <= 1'b1;
    n = 0;
    repeat (8) begin
      @(posedge clk_in);
      if (drv[1] !== 1'b0) n++;
    end
    chk(n, 0);
    chk(drv, 4'h5);
    src.pin_routed_input <= 1'b0;
    repeat (8) @(posedge clk_in);
    src.pin_routed_input <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk(drv, 4'hA);
    chk(shoot, 1'b0);
    arm <= 1'b0;
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CLK, 32'h1);
    rdchk(OFF_CLK, 32'h1);
    wr(OFF_RISE, 32'h4);
    src.pin_routed_input <= 1'b0;
    wr(OFF_CTRL, 32'h84);
    sleep <= 1'b1;
    repeat (40) @(posedge clk_in);
    edge_delay(1'b1, n);
    chk(n >= 24 && n <= 50, 1'b1);
    edge_delay(1'b0, d0f);
    edge_delay(1'b1, d0r);
    chk(n - d0r <= 7 && d0r - n <= 7, 1'b1);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CLK, 32'h0);
    wr(OFF_CTRL, 32'h84);
    edge_delay(1'b0, n);
    chk(n, 200);
    finish_test();
  end
endmodule // complementary_waveform_deadband_test
